// [pkg/dcsel_pkg.sv]
// constants for the channel two filter chain and oscillator select block
package dcsel_pkg;
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;
  // register indices, byte address is four times the index
  localparam logic [9:0]  IDX_CTRL      = 10'h350;
  localparam logic [9:0]  IDX_CHAIN     = 10'h351;
  localparam logic [9:0]  IDX_OSC       = 10'h354;
  localparam logic [9:0]  IDX_STATUS    = 10'h3f0;
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [7:0]  CHAIN_RST     = 8'h00;
  localparam logic [7:0]  OSC_RST       = 8'h00;
  localparam logic [7:0]  CTRL_WMASK    = 8'h7f;
  localparam logic [7:0]  CHAIN_WMASK   = 8'hf0;
  // field positions
  localparam int          CTRL_C2R_BIT  = 3;
  localparam int          CTRL_DEC_LSB  = 0;
  localparam int          CHAIN_EXT_LSB = 4;
  localparam int          OSC_MODE_LSB  = 4;
  localparam int          OSC_SEL_LSB   = 0;
  localparam int          STAT_CHAN_LSB = 0;
  localparam int          STAT_CNT_LSB  = 4;
  localparam int          STAT_DEC_LSB  = 8;
  localparam int          STAT_FLT_LSB  = 16;
  localparam int          STAT_EXT_BIT  = 22;
  localparam int          STAT_BAD_BIT  = 23;
  // filter enable mask bits
  localparam int          FLT_HALF1     = 0;
  localparam int          FLT_HALF2     = 1;
  localparam int          FLT_HALF3     = 2;
  localparam int          FLT_HALF4     = 3;
  localparam int          FLT_TB        = 4;
  localparam int          FLT_FB        = 5;
  // primary and extended codes
  localparam logic [2:0]  PRI_EXT       = 3'h7;
  localparam logic [3:0]  EXT_TB_HALF4  = 4'h0;
  localparam logic [3:0]  EXT_FB_HALF1  = 4'h2;
  localparam logic [3:0]  EXT_FB_HALF2  = 4'h3;
  localparam logic [3:0]  EXT_FB_HALF3  = 4'h4;
  // complex output decimation factors
  localparam logic [7:0]  DEC_P0        = 8'h04;
  localparam logic [7:0]  DEC_P1        = 8'h08;
  localparam logic [7:0]  DEC_P2        = 8'h10;
  localparam logic [7:0]  DEC_P3        = 8'h02;
  localparam logic [7:0]  DEC_P4        = 8'h06;
  localparam logic [7:0]  DEC_P5        = 8'h0c;
  localparam logic [7:0]  DEC_P6        = 8'h18;
  localparam logic [7:0]  DEC_E0        = 8'h30;
  localparam logic [7:0]  DEC_E2        = 8'h0a;
  localparam logic [7:0]  DEC_E3        = 8'h14;
  localparam logic [7:0]  DEC_E4        = 8'h28;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  typedef enum logic [3:0] {
    MODE_REG    = 4'b0000,
    MODE_PINS   = 4'b0001,
    MODE_EDGE_A = 4'b1000,
    MODE_EDGE_B = 4'b1010
  } dcsel_mode_t;
  typedef enum logic [2:0] {
    REG_NONE   = 3'b000,
    REG_CTRL   = 3'b001,
    REG_CHAIN  = 3'b010,
    REG_OSC    = 3'b011,
    REG_STATUS = 3'b100
  } dcsel_reg_t;
endpackage

// [pkg/dcsel_osc_if.sv]
// oscillator channel select signals between top and selector
`timescale 1ns/1ps
interface dcsel_osc_if;
  logic [3:0] mode;
  logic [3:0] map_sel;
  logic       pin_a;
  logic       pin_b;
  logic [3:0] active_chan;
  logic [3:0] count;
  modport ctl (output mode, map_sel, pin_a, pin_b,
               input active_chan, count);
  modport sel (input mode, map_sel, pin_a, pin_b,
               output active_chan, count);
endinterface

// [src/dcsel_osc_sel.sv]
// oscillator channel selector with pin and edge counter modes
`timescale 1ns/1ps
module dcsel_osc_sel (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // select controls and result
  dcsel_osc_if.sel  io
);
  logic       a_prev_reg;
  logic       b_prev_reg;
  logic [3:0] count_reg;
  logic [3:0] count_next;
  logic [3:0] chan_reg;
  logic       edge_hit;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      a_prev_reg <= 1'b0;
      b_prev_reg <= 1'b0;
    end else begin
      a_prev_reg <= io.pin_a;
      b_prev_reg <= io.pin_b;
    end
  end

  // rising edge of the pin chosen by the mode
  always_comb begin
    edge_hit = 1'b0;
    if (io.mode == dcsel_pkg::MODE_EDGE_A) begin
      edge_hit = io.pin_a & ~a_prev_reg; // R9
    end else if (io.mode == dcsel_pkg::MODE_EDGE_B) begin
      edge_hit = io.pin_b & ~b_prev_reg; // R10
    end
  end

  // wrap after the programmed value is reached
  always_comb begin
    if (count_reg >= io.map_sel) begin
      count_next = 4'h0; // R11
    end else begin
      count_next = count_reg + 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 4'h0;
    end else if (edge_hit) begin
      count_reg <= count_next;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chan_reg <= 4'h0;
    end else begin
      case (io.mode)
        dcsel_pkg::MODE_REG:    chan_reg <= io.map_sel; // R7
        dcsel_pkg::MODE_PINS:   chan_reg <= {2'b00, io.pin_b, io.pin_a}; // R8
        dcsel_pkg::MODE_EDGE_A: chan_reg <= count_reg; // R9
        dcsel_pkg::MODE_EDGE_B: chan_reg <= count_reg; // R10
        default:                chan_reg <= chan_reg; // R13
      endcase
    end
  end

  assign io.active_chan = chan_reg;
  assign io.count       = count_reg;

  sequence s_rise_a;
    (io.mode == 4'b1000 && !io.pin_a) ##1 (io.mode == 4'b1000 && io.pin_a);
  endsequence
  sequence s_rise_b;
    (io.mode == 4'b1010 && !io.pin_b) ##1 (io.mode == 4'b1010 && io.pin_b);
  endsequence

  AST_REG_MODE: assert property (@(posedge clk_sys) disable iff (!rst_n) // R7
    io.mode == 4'b0000 |=> io.active_chan == $past(io.map_sel))
    else $error("register mode channel wrong");
  AST_PIN_MODE: assert property (@(posedge clk_sys) disable iff (!rst_n) // R8
    io.mode == 4'b0001 |=> io.active_chan == {2'b00, $past(io.pin_b),
                                               $past(io.pin_a)})
    else $error("pin mode channel wrong");
  AST_EDGE_A: assert property (@(posedge clk_sys) disable iff (!rst_n) // R9
    s_rise_a |=> io.count == (($past(io.count) >= $past(io.map_sel)) ?
                 4'h0 : $past(io.count) + 4'h1) ##1
                 io.active_chan == $past(io.count))
    else $error("edge a did not advance counter");
  AST_EDGE_B: assert property (@(posedge clk_sys) disable iff (!rst_n) // R10
    s_rise_b |=> io.count == (($past(io.count) >= $past(io.map_sel)) ?
                 4'h0 : $past(io.count) + 4'h1) ##1
                 io.active_chan == $past(io.count))
    else $error("edge b did not advance counter");
  AST_WRAP: assert property (@(posedge clk_sys) disable iff (!rst_n) // R11
    (edge_hit && io.count == io.map_sel) |=> io.count == 4'h0)
    else $error("counter did not wrap");
  AST_RSVD_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n) // R13
    (io.mode != 4'b0000 && io.mode != 4'b0001 && io.mode != 4'b1000 &&
     io.mode != 4'b1010) |=> $stable(io.active_chan))
    else $error("reserved mode changed channel");
endmodule

// [src/dcsel_top.sv]
// channel two filter chain select and oscillator channel control
// Operation
// R1: extended field used only when primary is 111
// R2: complex-to-real bit halves the decimation
// R3: extended 0: thirdband plus four halfbands, 48/24
// R4: extended 10: fifthband plus stage one, 10/5
// R5: extended 11: fifthband plus stages one-two, 20/10
// R6: extended 100: fifthband plus stages one-three, 40/20
// R7: mode 0 takes channel from register field
// R8: mode 1 takes channel from pins b,a
// R9: mode 1000 counts rising edges of pin a
// R10: mode 1010 counts rising edges of pin b
// R11: edge counter wraps after programmed select value
// R12: four-bit select field picks channels 0..15
// R13: reserved modes hold the active channel
`timescale 1ns/1ps
module dcsel_top #(
  parameter int ADDR_W = dcsel_pkg::ADDR_W
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // general purpose pins
  input  wire logic              aux_pin_a,
  input  wire logic              aux_pin_b,
  // filter chain and channel results
  output logic [7:0]             decim_factor,
  output logic [5:0]             filter_en,
  output logic                   real_only,
  output logic                   ext_used,
  output logic                   chain_invalid,
  output logic [3:0]             active_chan
);
  typedef struct packed {
    logic [7:0] dec;
    logic [5:0] flt;
    logic       ext;
    logic       bad;
  } dcsel_chain_t;

  logic [7:0]  ctrl_reg;
  logic [7:0]  chain_reg;
  logic [7:0]  osc_reg;
  logic        awready_reg;
  logic        wready_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        arready_reg;
  logic        rvalid_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rdata_reg;
  logic        aw_have_reg;
  logic        w_have_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic [7:0]  wdata_reg;
  logic        wstrb0_reg;
  logic        aw_take;
  logic        w_take;
  logic        do_write;
  dcsel_pkg::dcsel_reg_t wsel;
  dcsel_pkg::dcsel_reg_t rsel;
  dcsel_chain_t chain_next;
  dcsel_chain_t cplx_next;
  dcsel_chain_t chain_out_reg;
  logic        real_reg;
  logic [31:0] status_word;

  dcsel_osc_if osc ();

  // word address decode shared by reads and writes
  function automatic dcsel_pkg::dcsel_reg_t reg_decode(
    input logic [ADDR_W-1:0] a
  );
    dcsel_pkg::dcsel_reg_t r;
    r = dcsel_pkg::REG_NONE;
    if (a[1:0] == 2'b00) begin
      if (a[11:2] == dcsel_pkg::IDX_CTRL) begin
        r = dcsel_pkg::REG_CTRL;
      end else if (a[11:2] == dcsel_pkg::IDX_CHAIN) begin
        r = dcsel_pkg::REG_CHAIN;
      end else if (a[11:2] == dcsel_pkg::IDX_OSC) begin
        r = dcsel_pkg::REG_OSC;
      end else if (a[11:2] == dcsel_pkg::IDX_STATUS) begin
        r = dcsel_pkg::REG_STATUS;
      end
    end
    return r;
  endfunction

  // filter mask from a list of stages
  function automatic logic [5:0] fmask(
    input logic tb,
    input logic fb,
    input logic [3:0] hb
  );
    return {fb, tb, hb};
  endfunction

  // filter chain decode
  function automatic dcsel_chain_t chain_decode(
    input logic [2:0] pri,
    input logic [3:0] ext,
    input logic       c2r
  );
    dcsel_chain_t c;
    c = '{dec: 8'h00, flt: 6'h00, ext: 1'b0, bad: 1'b0};
    case (pri)
      3'h0: c = '{dcsel_pkg::DEC_P0, fmask(1'b0, 1'b0, 4'h3), 1'b0, 1'b0};
      3'h1: c = '{dcsel_pkg::DEC_P1, fmask(1'b0, 1'b0, 4'h7), 1'b0, 1'b0};
      3'h2: c = '{dcsel_pkg::DEC_P2, fmask(1'b0, 1'b0, 4'hf), 1'b0, 1'b0};
      3'h3: c = '{dcsel_pkg::DEC_P3, fmask(1'b0, 1'b0, 4'h1), 1'b0, 1'b0};
      3'h4: c = '{dcsel_pkg::DEC_P4, fmask(1'b1, 1'b0, 4'h1), 1'b0, 1'b0};
      3'h5: c = '{dcsel_pkg::DEC_P5, fmask(1'b1, 1'b0, 4'h3), 1'b0, 1'b0};
      3'h6: c = '{dcsel_pkg::DEC_P6, fmask(1'b1, 1'b0, 4'h7), 1'b0, 1'b0};
      default: begin
        c.ext = 1'b1; // R1
        case (ext)
          dcsel_pkg::EXT_TB_HALF4: begin
            c.dec = dcsel_pkg::DEC_E0; // R3
            c.flt = fmask(1'b1, 1'b0, 4'hf);
          end
          dcsel_pkg::EXT_FB_HALF1: begin
            c.dec = dcsel_pkg::DEC_E2; // R4
            c.flt = fmask(1'b0, 1'b1, 4'h1);
          end
          dcsel_pkg::EXT_FB_HALF2: begin
            c.dec = dcsel_pkg::DEC_E3; // R5
            c.flt = fmask(1'b0, 1'b1, 4'h3);
          end
          dcsel_pkg::EXT_FB_HALF3: begin
            c.dec = dcsel_pkg::DEC_E4; // R6
            c.flt = fmask(1'b0, 1'b1, 4'h7);
          end
          default: c.bad = 1'b1;
        endcase
      end
    endcase
    if (c2r) begin
      c.dec = {1'b0, c.dec[7:1]}; // R2
    end
    return c;
  endfunction

  assign aw_take  = s_axi_awvalid & awready_reg;
  assign w_take   = s_axi_wvalid & wready_reg;
  assign do_write = aw_have_reg & w_have_reg & ~bvalid_reg;
  assign wsel     = reg_decode(waddr_reg);
  assign rsel     = reg_decode(s_axi_araddr);

  // write address and data, taken in either order
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_reg <= 1'b0;
      awready_reg <= 1'b1;
      waddr_reg   <= '0;
    end else if (aw_take) begin
      aw_have_reg <= 1'b1;
      awready_reg <= 1'b0;
      waddr_reg   <= s_axi_awaddr;
    end else if (do_write) begin
      aw_have_reg <= 1'b0;
    end else if (bvalid_reg && s_axi_bready) begin
      awready_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      w_have_reg <= 1'b0;
      wready_reg <= 1'b1;
      wdata_reg  <= 8'h00;
      wstrb0_reg <= 1'b0;
    end else if (w_take) begin
      w_have_reg <= 1'b1;
      wready_reg <= 1'b0;
      wdata_reg  <= s_axi_wdata[7:0];
      wstrb0_reg <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_have_reg <= 1'b0;
    end else if (bvalid_reg && s_axi_bready) begin
      wready_reg <= 1'b1;
    end
  end

  // write response
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= dcsel_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (wsel == dcsel_pkg::REG_NONE) ?
                    dcsel_pkg::RESP_SLVERR : dcsel_pkg::RESP_OKAY;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // register storage, low byte lane only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg  <= dcsel_pkg::CTRL_RST;
      chain_reg <= dcsel_pkg::CHAIN_RST;
      osc_reg   <= dcsel_pkg::OSC_RST;
    end else if (do_write && wstrb0_reg) begin
      case (wsel)
        dcsel_pkg::REG_CTRL:  ctrl_reg  <= wdata_reg & dcsel_pkg::CTRL_WMASK;
        dcsel_pkg::REG_CHAIN: chain_reg <= wdata_reg & dcsel_pkg::CHAIN_WMASK;
        dcsel_pkg::REG_OSC:   osc_reg   <= wdata_reg; // R12
        default:              osc_reg   <= osc_reg;
      endcase
    end
  end

  // filter chain selection
  assign chain_next = chain_decode(
    ctrl_reg[dcsel_pkg::CTRL_DEC_LSB +: 3],
    chain_reg[dcsel_pkg::CHAIN_EXT_LSB +: 4],
    ctrl_reg[dcsel_pkg::CTRL_C2R_BIT]);

  // complex output decode for the halving check
  assign cplx_next = chain_decode(
    ctrl_reg[dcsel_pkg::CTRL_DEC_LSB +: 3],
    chain_reg[dcsel_pkg::CHAIN_EXT_LSB +: 4],
    1'b0);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chain_out_reg <= '{dec: 8'h00, flt: 6'h00, ext: 1'b0, bad: 1'b0};
      real_reg      <= 1'b0;
    end else begin
      chain_out_reg <= chain_next;
      real_reg      <= ctrl_reg[dcsel_pkg::CTRL_C2R_BIT]; // R2
    end
  end

  // oscillator channel selector
  assign osc.mode    = osc_reg[dcsel_pkg::OSC_MODE_LSB +: 4];
  assign osc.map_sel = osc_reg[dcsel_pkg::OSC_SEL_LSB +: 4]; // R12
  assign osc.pin_a   = aux_pin_a;
  assign osc.pin_b   = aux_pin_b;

  dcsel_osc_sel u_osc (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .io      (osc.sel)
  );

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[dcsel_pkg::STAT_CHAN_LSB +: 4] = osc.active_chan;
    status_word[dcsel_pkg::STAT_CNT_LSB +: 4]  = osc.count;
    status_word[dcsel_pkg::STAT_DEC_LSB +: 8]  = chain_out_reg.dec;
    status_word[dcsel_pkg::STAT_FLT_LSB +: 6]  = chain_out_reg.flt;
    status_word[dcsel_pkg::STAT_EXT_BIT]       = chain_out_reg.ext;
    status_word[dcsel_pkg::STAT_BAD_BIT]       = chain_out_reg.bad;
  end

  // read channel
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= dcsel_pkg::RESP_OKAY;
      rdata_reg   <= 32'h0000_0000;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rresp_reg   <= dcsel_pkg::RESP_OKAY;
      case (rsel)
        dcsel_pkg::REG_CTRL:   rdata_reg <= {24'h00_0000, ctrl_reg};
        dcsel_pkg::REG_CHAIN:  rdata_reg <= {24'h00_0000, chain_reg};
        dcsel_pkg::REG_OSC:    rdata_reg <= {24'h00_0000, osc_reg};
        dcsel_pkg::REG_STATUS: rdata_reg <= status_word;
        default: begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= dcsel_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign decim_factor  = chain_out_reg.dec;
  assign filter_en     = chain_out_reg.flt;
  assign ext_used      = chain_out_reg.ext;
  assign chain_invalid = chain_out_reg.bad;
  assign real_only     = real_reg;
  assign active_chan   = osc.active_chan;

  sequence s_ext_sel(logic [3:0] code);
    ctrl_reg[2:0] == 3'h7 && chain_reg[7:4] == code;
  endsequence

  AST_EXT_IGNORED: assert property (@(posedge clk_sys) disable iff (!rst_n) // R1
    ctrl_reg[2:0] != 3'h7 |=> !ext_used && !chain_invalid)
    else $error("extended field used without primary all ones");
  AST_HALF: assert property (@(posedge clk_sys) disable iff (!rst_n) // R2
    (ctrl_reg[3] && $stable(ctrl_reg) && $stable(chain_reg)) |->
      real_only && decim_factor == {1'b0, cplx_next.dec[7:1]})
    else $error("real output decimation not halved");
  AST_EXT0: assert property (@(posedge clk_sys) disable iff (!rst_n) // R3
    s_ext_sel(4'h0) |=> decim_factor == ($past(ctrl_reg[3]) ? 8'h18 : 8'h30)
      && filter_en == 6'h1f)
    else $error("extended code 0 chain wrong");
  AST_EXT2: assert property (@(posedge clk_sys) disable iff (!rst_n) // R4
    s_ext_sel(4'h2) |=> decim_factor == ($past(ctrl_reg[3]) ? 8'h05 : 8'h0a)
      && filter_en == 6'h21)
    else $error("extended code 10 chain wrong");
  AST_EXT3: assert property (@(posedge clk_sys) disable iff (!rst_n) // R5
    s_ext_sel(4'h3) |=> decim_factor == ($past(ctrl_reg[3]) ? 8'h0a : 8'h14)
      && filter_en == 6'h23)
    else $error("extended code 11 chain wrong");
  AST_EXT4: assert property (@(posedge clk_sys) disable iff (!rst_n) // R6
    s_ext_sel(4'h4) |=> decim_factor == ($past(ctrl_reg[3]) ? 8'h14 : 8'h28)
      && filter_en == 6'h27)
    else $error("extended code 100 chain wrong");
  AST_SEL_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n) // R12
    (do_write && wstrb0_reg && wsel == dcsel_pkg::REG_OSC &&
     wdata_reg[7:4] == 4'h0) |=> ##1 active_chan == $past(wdata_reg[3:0], 2))
    else $error("register select not reflected on channel");
endmodule

// [sim/dcsel_top_tb.sv]
// self-checking bench for the filter chain and oscillator select block
`timescale 1ns/1ps
module dcsel_top_tb;
  localparam logic [1:0]  OK = dcsel_pkg::RESP_OKAY;
  localparam logic [1:0]  ER = dcsel_pkg::RESP_SLVERR;
  localparam logic [11:0] CT = {dcsel_pkg::IDX_CTRL, 2'b00};
  localparam logic [11:0] CH = {dcsel_pkg::IDX_CHAIN, 2'b00};
  localparam logic [11:0] OS = {dcsel_pkg::IDX_OSC, 2'b00};
  localparam logic [11:0] ST = {dcsel_pkg::IDX_STATUS, 2'b00};
  logic        clk_sys;
  logic        rst_n = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0;
  logic [11:0] s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        aux_pin_a = 1'b0;
  logic        aux_pin_b = 1'b0;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, real_only, ext_used, chain_invalid;
  logic [7:0]  decim_factor;
  logic [5:0]  filter_en;
  logic [3:0]  active_chan, cnt, act;
  logic [15:0] hi;
  logic [1:0]  bq[$];
  logic [33:0] rq[$];
  logic [7:0]  ecfg[4] = '{8'h83, 8'ha5, 8'ha0, 8'h8f};
  int          mismatches = 0;
  int          total_checks = 0;

  dcsel_top uut (
    .clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .aux_pin_a, .aux_pin_b, .decim_factor,
    .filter_en, .real_only, .ext_used, .chain_invalid, .active_chan
  );

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [33:0] e,
                     input logic [33:0] s);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // expected {invalid, ext used, filters, decimation}
  function automatic logic [15:0] ech(input logic [2:0] p,
                                      input logic [3:0] e, input logic c);
    logic [5:0] f;
    logic [7:0] d;
    case (p)
      3'h0: begin f = 6'h03; d = 8'h04; end
      3'h1: begin f = 6'h07; d = 8'h08; end
      3'h2: begin f = 6'h0f; d = 8'h10; end
      3'h3: begin f = 6'h01; d = 8'h02; end
      3'h4: begin f = 6'h11; d = 8'h06; end
      3'h5: begin f = 6'h13; d = 8'h0c; end
      3'h6: begin f = 6'h17; d = 8'h18; end
      default: begin
        case (e)
          4'h0: begin f = 6'h1f; d = 8'h30; end
          4'h2: begin f = 6'h21; d = 8'h0a; end
          4'h3: begin f = 6'h23; d = 8'h14; end
          4'h4: begin f = 6'h27; d = 8'h28; end
          default: begin f = 6'h00; d = 8'h00; end
        endcase
      end
    endcase
    if (c) d = d >> 1;
    return {p == 3'h7 && f == 6'h00, p == 3'h7, f, d};
  endfunction

  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [3:0] s, input logic [1:0] r);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    bq.push_back(r);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'($urandom), d};
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge clk_sys);
      if (!ta && s_axi_awready) begin
        ta = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!tw && s_axi_wready) begin
        tw = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [11:0] a, input logic [23:0] e,
                    input logic [1:0] r);
    rq.push_back({r, 8'h00, e});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask

  // pulse one pin, random level on the other
  task automatic pulse(input logic b);
    aux_pin_a <= b ? 1'($urandom) : 1'b1;
    aux_pin_b <= b ? 1'b1 : 1'($urandom);
    repeat (2) @(posedge clk_sys);
    aux_pin_a <= 1'b0;
    aux_pin_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  // response monitor
  always @(posedge clk_sys) begin
    if (s_axi_bvalid && s_axi_bready)
      chk("bresp", {32'h0, bq.pop_front()}, {32'h0, s_axi_bresp});
    if (s_axi_rvalid && s_axi_rready)
      chk("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
  end

  initial begin
    #(20000 * 50);
    mismatches++;
    test_done;
  end

  initial begin
    void'($urandom(32'h7c50_94fc));
    cnt = 4'h0;
    act = 4'h0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    // reset values, access kinds, refused accesses
    rd(CT, 24'h0, OK);
    rd(CH, 24'h0, OK);
    rd(OS, 24'h0, OK);
    rd(ST, {ech(3'h0, 4'h0, 1'b0), 8'h00}, OK);
    wr(CT, 8'hff, 4'hf, OK);
    rd(CT, 24'h7f, OK);
    wr(CH, 8'hff, 4'hf, OK);
    wr(CH, 8'h2a, 4'h0, OK);
    rd(CH, 24'hf0, OK);
    wr(ST, 8'h55, 4'hf, OK);
    rd(ST, {ech(3'h7, 4'hf, 1'b1), 8'h00}, OK);
    wr(12'h004, 8'h01, 4'hf, ER);
    rd(12'h004, 24'h0, ER);
    rd(12'hd42, 24'h0, ER);
    $display("test registers done");
    // every primary and extended code, both output kinds
    for (int c = 0; c < 2; c++) begin
      for (int p = 0; p < 8; p++) begin
        wr(CT, {1'b0, 3'($urandom), c[0], p[2:0]}, 4'h1, OK);
        for (int e = 0; e < 16; e++) begin
          wr(CH, {e[3:0], 4'($urandom)}, 4'h1, OK);
          hi = ech(p[2:0], e[3:0], c[0]);
          rd(ST, {hi, 8'h00}, OK);
          chk("chain", {18'h0, hi}, {18'h0, chain_invalid,
                        ext_used, filter_en, decim_factor});
          chk("real", {33'h0, c[0]}, {33'h0, real_only});
        end
      end
    end
    $display("test chain done");
    // channel from register field
    for (int s = 0; s < 16; s++) begin
      wr(OS, {4'h0, s[3:0]}, 4'h1, OK);
      act = s[3:0];
      rd(ST, {hi, cnt, act}, OK);
      chk("chan", {30'h0, act}, {30'h0, active_chan});
    end
    // channel from pins
    wr(OS, {4'h1, 4'($urandom)}, 4'h1, OK);
    for (int k = 0; k < 4; k++) begin
      aux_pin_a <= k[0];
      aux_pin_b <= k[1];
      repeat (3) @(posedge clk_sys);
      act = {2'b00, k[1], k[0]};
      rd(ST, {hi, cnt, act}, OK);
    end
    aux_pin_a <= 1'b0;
    aux_pin_b <= 1'b0;
    @(posedge clk_sys);
    $display("test direct select done");
    // edge counting with wrap limits
    for (int i = 0; i < 4; i++) begin
      wr(OS, ecfg[i], 4'h1, OK);
      for (int k = 0; k < 5; k++) begin
        pulse(ecfg[i][5]);
        cnt = (cnt >= ecfg[i][3:0]) ? 4'h0 : cnt + 4'h1;
        act = cnt;
        rd(ST, {hi, cnt, act}, OK);
      end
    end
    // reserved modes hold the channel
    for (int m = 0; m < 4; m++) begin
      wr(OS, {4'(m * 4 + 3), 4'($urandom)}, 4'h1, OK);
      pulse(1'b0);
      pulse(1'b1);
      rd(ST, {hi, cnt, act}, OK);
    end
    $display("test edge modes done");
    test_done;
  end
endmodule
